// *** shared/deep_sleep_gate_consts.vh ***
`ifndef DEEP_SLEEP_GATE_CONSTS_VH
`define DEEP_SLEEP_GATE_CONSTS_VH

// Register bus geometry.
`define ADDR_WIDTH 12
`define DATA_WIDTH 32
`define PORT_COUNT 8
`define PORT_SEL_WIDTH 3

// Register byte offsets.
`define OFFSET_SOFT_RESET_CONTROL_ZERO 12'h040
`define OFFSET_RUN_PORT_CLOCK_GATE 12'h100
`define OFFSET_SLEEP_PORT_CLOCK_GATE 12'h104
`define OFFSET_RUN_CLOCK_CONFIGURATION 12'h108
`define OFFSET_EVENT_STATUS 12'h10c
`define OFFSET_EVENT_MASK 12'h110
`define OFFSET_DEEP_SLEEP_PORT_CLOCK_GATE 12'h128

// Reset values.
`define RESET_WORD 32'h00000000
`define RESET_PORT_GATE 8'h00
`define RESET_EVENTS 2'h0

// Port gating field: port A at bit 0 through port H at bit 7.
`define PORT_GATE_MSB 7
`define PORT_GATE_LSB 0
`define PORT_GATE_PAD 24'h000000

// Soft reset control fields.
`define SOFT_RESET_CONVERTER_BIT 16
`define SOFT_RESET_HIBERNATION_BIT 6
`define SOFT_RESET_WATCHDOG_BIT 3
`define SOFT_RESET_WRITABLE 32'h00010048

// Run clock configuration field.
`define AUTO_CLOCK_GATING_BIT 0

// Event status and mask fields.
`define EVENT_WIDTH 2
`define EVENT_PORT_FAULT_BIT 0
`define EVENT_MASKED_WRITE_BIT 1
`define EVENT_PAD 30'h00000000

// Power mode codes.
`define MODE_WIDTH 2
`define MODE_RUN 2'h0
`define MODE_SLEEP 2'h1
`define MODE_DEEP_SLEEP 2'h2

`endif

// *** core/port_access_guard.v ***
`timescale 1ns/1ps
`default_nettype none
`include "deep_sleep_gate_consts.vh"

module port_access_guard
(
    input wire clk_in,
    input wire reset_in,
    input wire [`MODE_WIDTH-1:0] power_mode_in,
    input wire auto_clock_gating_select_in,
    input wire [`PORT_COUNT-1:0] run_gate_in,
    input wire [`PORT_COUNT-1:0] sleep_gate_in,
    input wire [`PORT_COUNT-1:0] deep_gate_in,
    input wire access_valid_in,
    input wire [`PORT_SEL_WIDTH-1:0] access_port_in,
    output reg [`PORT_COUNT-1:0] clock_enable_out,
    output reg access_done_out,
    output reg access_fault_out
);

    wire [`PORT_COUNT-1:0] next_clock_enable;

    // Without automatic gating the sleep modes keep the run-mode enables.
    genvar i;
    generate
        for (i = 0; i < `PORT_COUNT; i = i + 1)
        begin : gate_select
            assign next_clock_enable[i] =
                !auto_clock_gating_select_in ? run_gate_in[i] :
                (power_mode_in == `MODE_DEEP_SLEEP) ? deep_gate_in[i] :
                (power_mode_in == `MODE_SLEEP) ? sleep_gate_in[i] :
                run_gate_in[i];
        end
    endgenerate

    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            clock_enable_out <= `RESET_PORT_GATE;
            access_done_out <= 1'b0;
            access_fault_out <= 1'b0;
        end
        else
        begin
            clock_enable_out <= next_clock_enable;
            access_done_out <= access_valid_in && clock_enable_out[access_port_in];
            access_fault_out <= access_valid_in && !clock_enable_out[access_port_in];
        end
    end

endmodule
`default_nettype wire

// *** core/deep_sleep_gate_and_soft_reset.v ***
// Operation
// - A port whose deep-sleep gating bit is 1 gets its clock in deep-sleep; at 0 it is unclocked.
// - Any access aimed at a port whose clock is gated off ends in a bus fault.
// - After reset every gating bit reads 0 and the deep-sleep gating register is all zeros.
// - Enables come from the run register in run, the sleep register in sleep, deep in deep-sleep.
// - Sleep and deep-sleep registers govern only while automatic clock gating is selected.
// - The deep-sleep gating register holds ports A to H in bits 0 to 7; bits 31:8 read zero.
// - Writes to the soft reset register are masked by the device capabilities word.
// - Soft reset bits are converter 16, hibernation 6, watchdog 3; others read zero; reset 0.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "deep_sleep_gate_consts.vh"

module deep_sleep_gate_and_soft_reset
(
    input wire clk_in,
    input wire reset_in,
    input wire [`ADDR_WIDTH-1:0] address_in,
    input wire [`DATA_WIDTH-1:0] write_data_in,
    input wire write_strobe_in,
    input wire read_strobe_in,
    output reg [`DATA_WIDTH-1:0] read_data_out,
    input wire [`MODE_WIDTH-1:0] power_mode_in,
    input wire [`DATA_WIDTH-1:0] device_capabilities_one_in,
    input wire port_access_valid_in,
    input wire [`PORT_SEL_WIDTH-1:0] port_access_select_in,
    output wire [`PORT_COUNT-1:0] port_clock_enable_out,
    output wire port_access_done_out,
    output wire port_bus_fault_out,
    output reg converter_reset_out,
    output reg hibernation_reset_control_out,
    output reg watchdog_reset_control_out,
    output reg interrupt_out
);

    reg [`DATA_WIDTH-1:0] soft_reset_control_zero;
    reg [`PORT_COUNT-1:0] run_port_clock_gate;
    reg [`PORT_COUNT-1:0] sleep_port_clock_gate;
    reg [`PORT_COUNT-1:0] deep_sleep_port_clock_gate;
    reg auto_clock_gating_select;
    reg [`EVENT_WIDTH-1:0] event_status;
    reg [`EVENT_WIDTH-1:0] event_mask;

    reg [`DATA_WIDTH-1:0] next_read_data;
    reg [`DATA_WIDTH-1:0] next_soft_reset;
    reg [`EVENT_WIDTH-1:0] new_events;
    reg [`EVENT_WIDTH-1:0] next_event_status;
    reg [`PORT_COUNT-1:0] next_run_gate;
    reg [`PORT_COUNT-1:0] next_sleep_gate;
    reg [`PORT_COUNT-1:0] next_deep_gate;
    reg next_auto_select;
    reg [`EVENT_WIDTH-1:0] next_event_mask;
    reg next_interrupt;

    wire write_soft_reset;
    wire write_run_gate;
    wire write_sleep_gate;
    wire write_deep_gate;
    wire write_configuration;
    wire write_mask;
    wire read_status;
    wire fault_event;
    wire [`DATA_WIDTH-1:0] soft_reset_write_enable;

    assign write_soft_reset = write_strobe_in &&
        (address_in == `OFFSET_SOFT_RESET_CONTROL_ZERO);
    assign write_run_gate = write_strobe_in &&
        (address_in == `OFFSET_RUN_PORT_CLOCK_GATE);
    assign write_sleep_gate = write_strobe_in &&
        (address_in == `OFFSET_SLEEP_PORT_CLOCK_GATE);
    assign write_deep_gate = write_strobe_in &&
        (address_in == `OFFSET_DEEP_SLEEP_PORT_CLOCK_GATE);
    assign write_configuration = write_strobe_in &&
        (address_in == `OFFSET_RUN_CLOCK_CONFIGURATION);
    assign write_mask = write_strobe_in &&
        (address_in == `OFFSET_EVENT_MASK);
    assign read_status = read_strobe_in &&
        (address_in == `OFFSET_EVENT_STATUS);

    // Only bits that exist and that the capability word reports present are writable.
    assign soft_reset_write_enable = `SOFT_RESET_WRITABLE & device_capabilities_one_in;

    // The guard owns the per-port enable selection and the bus fault answer.
    port_access_guard guard
    (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .power_mode_in(power_mode_in),
        .auto_clock_gating_select_in(auto_clock_gating_select),
        .run_gate_in(run_port_clock_gate),
        .sleep_gate_in(sleep_port_clock_gate),
        .deep_gate_in(deep_sleep_port_clock_gate),
        .access_valid_in(port_access_valid_in),
        .access_port_in(port_access_select_in),
        .clock_enable_out(port_clock_enable_out),
        .access_done_out(port_access_done_out),
        .access_fault_out(fault_event)
    );

    assign port_bus_fault_out = fault_event;

    // Soft reset write value: writable bits follow the data, others keep zero.
    always @*
    begin
        next_soft_reset = soft_reset_control_zero;
        if (write_soft_reset)
        begin
            next_soft_reset = write_data_in & soft_reset_write_enable;
        end
    end

    // Events raised this cycle: a faulted port access, and a soft reset write
    // that tried to set a bit the capability word masks away.
    always @*
    begin
        new_events = `RESET_EVENTS;
        new_events[`EVENT_PORT_FAULT_BIT] = fault_event;
        new_events[`EVENT_MASKED_WRITE_BIT] = write_soft_reset &&
            ((write_data_in & `SOFT_RESET_WRITABLE & ~device_capabilities_one_in) != `RESET_WORD);
    end

    // A read of the status clears it, but an event in the same cycle survives.
    always @*
    begin
        next_event_status = event_status;
        if (read_status)
        begin
            next_event_status = `RESET_EVENTS;
        end
        next_event_status = next_event_status | new_events;
    end

    // Read mux; reserved bits and unmapped offsets read zero.
    always @*
    begin
        next_read_data = `RESET_WORD;
        if (address_in == `OFFSET_SOFT_RESET_CONTROL_ZERO)
        begin
            next_read_data = soft_reset_control_zero;
        end
        else if (address_in == `OFFSET_DEEP_SLEEP_PORT_CLOCK_GATE)
        begin
            next_read_data = {`PORT_GATE_PAD, deep_sleep_port_clock_gate};
        end
        else if (address_in == `OFFSET_RUN_PORT_CLOCK_GATE)
        begin
            next_read_data = {`PORT_GATE_PAD, run_port_clock_gate};
        end
        else if (address_in == `OFFSET_SLEEP_PORT_CLOCK_GATE)
        begin
            next_read_data = {`PORT_GATE_PAD, sleep_port_clock_gate};
        end
        else if (address_in == `OFFSET_RUN_CLOCK_CONFIGURATION)
        begin
            next_read_data[`AUTO_CLOCK_GATING_BIT] = auto_clock_gating_select;
        end
        else if (address_in == `OFFSET_EVENT_STATUS)
        begin
            next_read_data = {`EVENT_PAD, event_status};
        end
        else if (address_in == `OFFSET_EVENT_MASK)
        begin
            next_read_data = {`EVENT_PAD, event_mask};
        end
        else
        begin
            next_read_data = `RESET_WORD;
        end
    end

    // Gate and configuration write values; an unaddressed register keeps its value.
    always @*
    begin
        next_run_gate = run_port_clock_gate;
        next_sleep_gate = sleep_port_clock_gate;
        next_deep_gate = deep_sleep_port_clock_gate;
        next_auto_select = auto_clock_gating_select;
        if (write_run_gate)
        begin
            next_run_gate = write_data_in[`PORT_GATE_MSB:`PORT_GATE_LSB];
        end
        if (write_sleep_gate)
        begin
            next_sleep_gate = write_data_in[`PORT_GATE_MSB:`PORT_GATE_LSB];
        end
        if (write_deep_gate)
        begin
            next_deep_gate = write_data_in[`PORT_GATE_MSB:`PORT_GATE_LSB];
        end
        if (write_configuration)
        begin
            next_auto_select = write_data_in[`AUTO_CLOCK_GATING_BIT];
        end
    end

    // Run-mode gating register.
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            run_port_clock_gate <= `RESET_PORT_GATE;
        end
        else
        begin
            run_port_clock_gate <= next_run_gate;
        end
    end

    // Sleep gating register.
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sleep_port_clock_gate <= `RESET_PORT_GATE;
        end
        else
        begin
            sleep_port_clock_gate <= next_sleep_gate;
        end
    end

    // Deep-sleep gating register; every port starts unclocked.
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            deep_sleep_port_clock_gate <= `RESET_PORT_GATE;
        end
        else
        begin
            deep_sleep_port_clock_gate <= next_deep_gate;
        end
    end

    // Automatic gating select; while clear the sleep modes keep the run enables.
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            auto_clock_gating_select <= 1'b0;
        end
        else
        begin
            auto_clock_gating_select <= next_auto_select;
        end
    end

    // Soft reset register.
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            soft_reset_control_zero <= `RESET_WORD;
        end
        else
        begin
            soft_reset_control_zero <= next_soft_reset;
        end
    end

    // Module reset outputs follow the register bits from the write edge on.
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            converter_reset_out <= 1'b0;
            hibernation_reset_control_out <= 1'b0;
            watchdog_reset_control_out <= 1'b0;
        end
        else
        begin
            converter_reset_out <= next_soft_reset[`SOFT_RESET_CONVERTER_BIT];
            hibernation_reset_control_out <= next_soft_reset[`SOFT_RESET_HIBERNATION_BIT];
            watchdog_reset_control_out <= next_soft_reset[`SOFT_RESET_WATCHDOG_BIT];
        end
    end

    // A mask write takes effect at once, so the interrupt level uses the new mask.
    always @*
    begin
        next_event_mask = event_mask;
        if (write_mask)
        begin
            next_event_mask = write_data_in[`EVENT_WIDTH-1:0];
        end
        next_interrupt = |(next_event_status & next_event_mask);
    end

    // Event status, mask and the level interrupt.
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            event_status <= `RESET_EVENTS;
        end
        else
        begin
            event_status <= next_event_status;
        end
    end

    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            event_mask <= `RESET_EVENTS;
        end
        else
        begin
            event_mask <= next_event_mask;
        end
    end

    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            interrupt_out <= 1'b0;
        end
        else
        begin
            interrupt_out <= next_interrupt;
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            read_data_out <= `RESET_WORD;
        end
        else if (read_strobe_in)
        begin
            read_data_out <= next_read_data;
        end
        else
        begin
            read_data_out <= `RESET_WORD;
        end
    end

endmodule
`default_nettype wire

// *** tb/deep_sleep_gate_and_soft_reset_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "deep_sleep_gate_consts.vh"

module gate_reset_checker
(
    input wire clk_in,
    input wire reset_in,
    input wire [`ADDR_WIDTH-1:0] address_in,
    input wire [`DATA_WIDTH-1:0] write_data_in,
    input wire write_strobe_in,
    input wire read_strobe_in,
    input wire [`DATA_WIDTH-1:0] read_data_out,
    input wire [`DATA_WIDTH-1:0] device_capabilities_one_in,
    input wire port_access_valid_in,
    input wire [`PORT_SEL_WIDTH-1:0] port_access_select_in,
    input wire [`PORT_COUNT-1:0] port_clock_enable_out,
    input wire port_access_done_out,
    input wire port_bus_fault_out,
    input wire converter_reset_out,
    input wire hibernation_reset_control_out,
    input wire watchdog_reset_control_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    wire soft_wr = write_strobe_in && address_in == `OFFSET_SOFT_RESET_CONTROL_ZERO;
    wire [2:0] soft_out = {converter_reset_out, hibernation_reset_control_out,
        watchdog_reset_control_out};
    wire gated = !port_clock_enable_out[port_access_select_in];

    a_fault_when_gated: assert property (
        port_access_valid_in && gated |=> port_bus_fault_out && !port_access_done_out)
        else $error("gated access did not fault");
    a_done_when_clocked: assert property (
        port_access_valid_in && !gated |=> port_access_done_out && !port_bus_fault_out)
        else $error("clocked access did not complete");
    a_reset_clears_all: assert property (
        $fell(reset_in) |-> port_clock_enable_out == 8'h00 && soft_out == 3'h0)
        else $error("outputs not cleared by reset");
    a_soft_write_masked: assert property (
        soft_wr |=> converter_reset_out == $past(write_data_in[16] & device_capabilities_one_in[16]))
        else $error("soft reset write not masked");
    a_soft_bit_places: assert property (
        soft_wr && device_capabilities_one_in == 32'hffffffff
        |=> soft_out == $past({write_data_in[16], write_data_in[6], write_data_in[3]}))
        else $error("soft reset bits misplaced");
    a_soft_reset_held: assert property (
        !soft_wr |=> $stable(soft_out))
        else $error("module reset changed without a write");
    a_gate_pad_zero: assert property (
        read_strobe_in && address_in == `OFFSET_DEEP_SLEEP_PORT_CLOCK_GATE
        |=> read_data_out[31:8] == 24'h000000)
        else $error("gate reserved bits not zero");
    a_soft_pad_zero: assert property (
        read_strobe_in && address_in == `OFFSET_SOFT_RESET_CONTROL_ZERO
        |=> (read_data_out & ~`SOFT_RESET_WRITABLE) == 32'h00000000)
        else $error("soft reset reserved bits not zero");

    c_fault: cover property (port_bus_fault_out);
    c_done: cover property (port_access_done_out);
    c_soft: cover property (soft_wr ##1 converter_reset_out);
endmodule

bind deep_sleep_gate_and_soft_reset gate_reset_checker u_checker (
    .clk_in(clk_in), .reset_in(reset_in), .address_in(address_in),
    .write_data_in(write_data_in), .write_strobe_in(write_strobe_in),
    .read_strobe_in(read_strobe_in), .read_data_out(read_data_out),
    .device_capabilities_one_in(device_capabilities_one_in),
    .port_access_valid_in(port_access_valid_in),
    .port_access_select_in(port_access_select_in),
    .port_clock_enable_out(port_clock_enable_out),
    .port_access_done_out(port_access_done_out), .port_bus_fault_out(port_bus_fault_out),
    .converter_reset_out(converter_reset_out),
    .hibernation_reset_control_out(hibernation_reset_control_out),
    .watchdog_reset_control_out(watchdog_reset_control_out));
`default_nettype wire

// *** tb/deep_sleep_gate_and_soft_reset_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module deep_sleep_gate_and_soft_reset_tb;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [11:0] address_in = 12'h000;
    logic [31:0] write_data_in = 32'h00000000;
    logic write_strobe_in = 1'b0;
    logic read_strobe_in = 1'b0;
    logic [1:0] power_mode_in = 2'h0;
    logic [31:0] device_capabilities_one_in = 32'hffffffff;
    logic port_access_valid_in = 1'b0;
    logic [2:0] port_access_select_in = 3'h0;
    wire [31:0] read_data_out;
    wire [7:0] port_clock_enable_out;
    wire port_access_done_out, port_bus_fault_out, converter_reset_out;
    wire hibernation_reset_control_out, watchdog_reset_control_out, interrupt_out;
    int miscompares = 0;
    int compares = 0;
    int i;

    always #5 clk_in = ~clk_in;

    deep_sleep_gate_and_soft_reset DUT (
        .clk_in(clk_in), .reset_in(reset_in), .address_in(address_in),
        .write_data_in(write_data_in), .write_strobe_in(write_strobe_in),
        .read_strobe_in(read_strobe_in), .read_data_out(read_data_out),
        .power_mode_in(power_mode_in), .device_capabilities_one_in(device_capabilities_one_in),
        .port_access_valid_in(port_access_valid_in),
        .port_access_select_in(port_access_select_in),
        .port_clock_enable_out(port_clock_enable_out),
        .port_access_done_out(port_access_done_out), .port_bus_fault_out(port_bus_fault_out),
        .converter_reset_out(converter_reset_out),
        .hibernation_reset_control_out(hibernation_reset_control_out),
        .watchdog_reset_control_out(watchdog_reset_control_out),
        .interrupt_out(interrupt_out));

    task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Each of wr, rd and acc drives on a rising edge, lets the taking edge pass, and ends mid-cycle
    // where the answer stands; a strobe is never lowered and raised in one time step.
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        address_in <= a;
        write_data_in <= d;
        write_strobe_in <= 1'b1;
        @(posedge clk_in);
        write_strobe_in <= 1'b0;
        @(negedge clk_in);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_in);
        address_in <= a;
        read_strobe_in <= 1'b1;
        @(posedge clk_in);
        read_strobe_in <= 1'b0;
        @(negedge clk_in);
        cmp("read data", e, read_data_out);
    endtask

    task acc(input logic [2:0] s, input logic f);
        @(posedge clk_in);
        port_access_select_in <= s;
        port_access_valid_in <= 1'b1;
        @(posedge clk_in);
        port_access_valid_in <= 1'b0;
        @(negedge clk_in);
        cmp("fault and done", {30'h0, f, !f}, {30'h0, port_bus_fault_out, port_access_done_out});
    endtask

    task settle;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    task report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #20000;
        miscompares++;
        report_and_stop;
    end

    initial
    begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        @(negedge clk_in);
        cmp("enable", 32'h0, {24'h0, port_clock_enable_out});
        rd(12'h128, 32'h0);
        rd(12'h040, 32'h0);
        rd(12'h7fc, 32'h0);
        acc(3'h2, 1'b1);
        settle;
        cmp("interrupt", 32'h0, {31'h0, interrupt_out});
        rd(12'h10c, 32'h1);
        rd(12'h10c, 32'h0);
        wr(12'h110, 32'h1);
        acc(3'h2, 1'b1);
        settle;
        cmp("interrupt", 32'h1, {31'h0, interrupt_out});
        rd(12'h10c, 32'h1);
        settle;
        cmp("interrupt", 32'h0, {31'h0, interrupt_out});
        wr(12'h100, 32'hffffff05);
        rd(12'h100, 32'h05);
        cmp("enable", 32'h05, {24'h0, port_clock_enable_out});
        acc(3'h0, 1'b0);
        acc(3'h1, 1'b1);
        wr(12'h128, 32'h000000a0);
        wr(12'h104, 32'h3c);
        rd(12'h128, 32'ha0);
        @(posedge clk_in);
        power_mode_in <= 2'h2;
        settle;
        cmp("enable", 32'h05, {24'h0, port_clock_enable_out});
        wr(12'h108, 32'h1);
        settle;
        cmp("enable", 32'ha0, {24'h0, port_clock_enable_out});
        for (i = 0; i < 8; i++)
            acc(i[2:0], ((8'ha0 >> i) & 8'h01) == 8'h00);
        @(posedge clk_in);
        power_mode_in <= 2'h1;
        settle;
        cmp("enable", 32'h3c, {24'h0, port_clock_enable_out});
        wr(12'h040, 32'hffffffff);
        rd(12'h040, 32'h00010048);
        cmp("module resets", 32'h7, {29'h0, converter_reset_out,
            hibernation_reset_control_out, watchdog_reset_control_out});
        wr(12'h040, 32'h0);
        cmp("module resets", 32'h0, {29'h0, converter_reset_out,
            hibernation_reset_control_out, watchdog_reset_control_out});
        @(posedge clk_in);
        device_capabilities_one_in <= 32'h00000008;
        wr(12'h040, 32'h00010048);
        rd(12'h040, 32'h00000008);
        cmp("module resets", 32'h1, {29'h0, converter_reset_out,
            hibernation_reset_control_out, watchdog_reset_control_out});
        settle;
        rd(12'h10c, 32'h3);
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        @(negedge clk_in);
        cmp("enable", 32'h0, {24'h0, port_clock_enable_out});
        cmp("module resets", 32'h0, {29'h0, converter_reset_out,
            hibernation_reset_control_out, watchdog_reset_control_out});
        cmp("interrupt", 32'h0, {31'h0, interrupt_out});
        rd(12'h128, 32'h0);
        rd(12'h040, 32'h0);
        report_and_stop;
    end
endmodule
`default_nettype wire
